// [bench/isp_port_chk.sv]
// Concurrent checks on the pins and array side of isp_port.
// Assumes binding onto isp_port and a serial clock phase of several mclk cycles.
module isp_port_chk
    import isp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Programming pins
    input wire logic prog_reset_n,
    input wire logic prog_sck,
    input wire logic prog_serial_in,
    input wire logic prog_serial_out,
    // Status
    input wire logic prog_mode,
    input wire logic operation_pending_flag,
    input wire logic [7:0] lock_bits,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] fuse_ext,
    // Array side
    input wire logic rd_req,
    input wire isp_pkg::rd_req_s rd_info,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic nvm_valid,
    input wire isp_pkg::nvm_req_s nvm_req,
    input wire logic nvm_ready
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    out_fall_edge_a: assert property ($changed(prog_serial_out) |-> !$past(prog_sck, 2))
        else $error("serial output moved while clock high");
    mode_exit_a: assert property (prog_reset_n [*6] |-> !prog_mode)
        else $error("programming mode kept with reset pin high");
    read_needs_mode_a: assert property (rd_req |-> prog_mode)
        else $error("array read outside programming mode");
    read_pulse_a: assert property (rd_req |=> !rd_req)
        else $error("read request longer than one cycle");
    info_hold_a: assert property ($changed(rd_info) |-> rd_req)
        else $error("read address changed without request");
    push_needs_mode_a: assert property ($rose(nvm_valid) |-> prog_mode)
        else $error("write request outside programming mode");
    pend_fifo_a: assert property (nvm_valid |-> operation_pending_flag)
        else $error("queued request without pending flag");
    erase_ones_a: assert property (nvm_valid && nvm_req.op == NVM_CHIP_ERASE |-> nvm_req.data == ERASED_BYTE)
        else $error("chip erase without all-ones data");
    fuse_mode_a: assert property ($changed({lock_bits, fuse_low, fuse_high, fuse_ext}) |-> $past(prog_mode))
        else $error("fuse or lock changed outside programming mode");
endmodule

// [bench/isp_programmer.sv]
// Behavioural serial programmer driving the port pins.
// Assumes the caller spaces frames and polls before each write.
module isp_programmer (
    // Programming pins
    output logic prog_reset_n,
    output logic prog_sck,
    output logic prog_serial_in,
    input wire logic prog_serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Pins and frames
    // ----------------------------------------
    initial begin
        prog_reset_n = 1'b0;
        prog_sck = 1'b0;
        prog_serial_in = 1'b0;
    end
    task automatic set_reset(input logic v);
        prog_reset_n = v;
    endtask
    // Clock stands low between frames; 62.5 ns phases, well over the sampling need
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            prog_serial_in = tx[i];
            #62.5;
            prog_sck = 1'b1;
            rx[i] = prog_serial_out;
            #62.5;
            prog_sck = 1'b0;
        end
        prog_serial_in = ~tx[0];
    endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the serial programming port.
// Assumes isp_programmer on the pins and a one-cycle array model kept here.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import isp_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, nvm_ready = 1'b0, rd_valid = 1'b0, stall = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic prog_reset_n, prog_sck, prog_serial_in, prog_serial_out, prog_mode, operation_pending_flag;
    logic rd_req, nvm_valid;
    logic [7:0] lock_bits, fuse_low, fuse_high, fuse_ext;
    rd_req_s rd_info;
    nvm_req_s nvm_req;
    nvm_req_s log_q[$];
    logic [31:0] rx;
    int n_errors = 0, n_tests = 0;
    // Signature and calibration bytes keep their neutral defaults; select 3 reads erased
    localparam logic [7:0] SIGS [4] = '{8'h00, 8'h00, 8'h00, ERASED_BYTE};
    isp_port #(.FLASH_WAIT(2000), .EEPROM_WAIT(1600), .ERASE_WAIT(3000))
        i_isp_port (.mclk(mclk), .rst_n(rst_n), .prog_reset_n(prog_reset_n),
        .prog_sck(prog_sck), .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
        .prog_mode(prog_mode), .operation_pending_flag(operation_pending_flag), .lock_bits(lock_bits),
        .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext), .rd_req(rd_req), .rd_info(rd_info),
        .rd_valid(rd_valid), .rd_data(rd_data), .nvm_valid(nvm_valid), .nvm_req(nvm_req), .nvm_ready(nvm_ready));
    isp_programmer i_isp_programmer (.prog_reset_n(prog_reset_n), .prog_sck(prog_sck),
        .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out));
    // ----------------------------------------
    // Clock, array model and helpers
    // ----------------------------------------
    initial forever #5 mclk = ~mclk;
    function automatic logic [7:0] arr(input rd_req_s r);
        return r.addr[7:0] ^ r.addr[15:8] ^ {r.eeprom, 6'h00, r.hi};
    endfunction
    // Data lines show garbage outside the answer cycle
    always @(posedge mclk) begin
        rd_valid <= rd_req;
        rd_data <= arr(rd_info) ^ {8{~rd_req}};
        nvm_ready <= ~stall;
        if (nvm_valid && nvm_ready)
            log_q.push_back(nvm_req);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic xf(input logic [31:0] tx);
        i_isp_programmer.frame(tx, rx);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            xf(32'hf0000000);
            if (rx[0] === 1'b0) break;
        end
        chk(rx[7:0], 8'h00);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_enable();
        xf(32'h4c120000);
        cyc(5);
        chk(prog_mode, 1'b0);
        chk(log_q.size(), 0);
        xf(32'hac530000);
        chk(rx[15:8], OP2_ENABLE);
        cyc(5);
        chk(prog_mode, 1'b1);
        $display("t_enable done");
    endtask
    task automatic t_fuse();
        logic [7:0] wr2 [4] = '{OP2_WR_LOCK, OP2_WR_FUSE_LO, OP2_WR_FUSE_HI, OP2_WR_FUSE_EXT};
        logic [15:0] rd [4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
        chk({lock_bits, fuse_low, fuse_high, fuse_ext}, 32'hffffffff);
        for (int k = 0; k < 4; k++) begin
            xf({OP_AC, wr2[k], 8'h00, 8'hf0 + 8'(k)});
            xf(32'hf0000000);
            chk(rx[0], 1'b1);
            wait_idle();
            xf({rd[k], 16'h0000});
            chk(rx[7:0], 8'hf0 + 8'(k));
        end
        chk({lock_bits, fuse_low, fuse_high, fuse_ext}, 32'hf0f1f2f3);
        $display("t_fuse done");
    endtask
    task automatic t_read();
        xf(32'h4d000500);
        xf(32'h20123400);
        chk(rd_info, {2'b00, 24'h051234});
        chk(rx[7:0], arr({2'b00, 24'h051234}));
        xf(32'h28123400);
        chk(rx[7:0], arr({2'b01, 24'h051234}));
        xf(32'ha00abc00);
        chk(rd_info, {2'b10, 24'h000abc});
        chk(rx[7:0], arr({2'b10, 24'h000abc}));
        for (int s = 0; s < 4; s++) begin
            xf({16'h3000, 8'(s), 8'h00});
            chk(rx[7:0], SIGS[s]);
        end
        // Non-zero third byte: a missed load would show its echo
        xf(32'h38005a00);
        chk(rx[7:0], 8'h00);
        $display("t_read done");
    endtask
    task automatic t_write();
        logic [31:0] fr [7] = '{32'h40008311, 32'h48008322, 32'h4c120000, 32'hc1000633, 32'hc00abc44,
            32'hc20abf00, 32'hac800000};
        nvm_req_s ex [7] = '{{NVM_LOAD_LO, 24'h3, 8'h11}, {NVM_LOAD_HI, 24'h3, 8'h22},
            {NVM_WRITE_PAGE, 24'h051200, 8'h0}, {NVM_EE_LOAD, 24'h2, 8'h33}, {NVM_EE_WRITE, 24'habc, 8'h44},
            {NVM_EE_WRITE_PAGE, 24'habc, 8'h0}, {NVM_CHIP_ERASE, 24'h0, 8'hff}};
        logic [1:0] m [7] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
        log_q.delete();
        for (int i = 0; i < 7; i++) begin
            xf(fr[i]);
            wait_idle();
            chk(log_q.size(), i + 1);
            chk(log_q[i].op, ex[i].op);
            if (m[i][1])
                chk(log_q[i].addr, ex[i].addr);
            if (m[i][0])
                chk(log_q[i].data, ex[i].data);
        end
        chk(lock_bits, 8'hff);
        $display("t_write done");
    endtask
    task automatic t_fifo();
        log_q.delete();
        stall <= 1'b1;
        for (int i = 0; i < 34; i++)
            xf({16'h4000, 8'(i), 8'(i)});
        chk({nvm_valid, operation_pending_flag}, 2'b11);
        stall <= 1'b0;
        cyc(80);
        chk(log_q.size(), FIFO_DEPTH);
        chk(log_q[FIFO_DEPTH-1].data, 8'(FIFO_DEPTH - 1));
        chk(operation_pending_flag, 1'b0);
        $display("t_fifo done");
    endtask
    task automatic t_exit();
        i_isp_programmer.set_reset(1'b1);
        cyc(20);
        chk(prog_mode, 1'b0);
        i_isp_programmer.set_reset(1'b0);
        cyc(10);
        log_q.delete();
        xf(32'hc0000155);
        cyc(10);
        chk(log_q.size(), 0);
        xf(32'hac530000);
        chk(rx[15:8], OP2_ENABLE);
        $display("t_exit done");
    endtask
    initial begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(2000);
        t_enable();
        t_fuse();
        t_read();
        t_write();
        t_fifo();
        t_exit();
        print_verdict();
    end
    initial begin
        cyc(90000);
        n_errors++;
        print_verdict();
    end
endmodule
bind isp_port isp_port_chk i_isp_port_chk (.mclk(mclk), .rst_n(rst_n), .prog_reset_n(prog_reset_n),
    .prog_sck(prog_sck), .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
    .prog_mode(prog_mode), .operation_pending_flag(operation_pending_flag), .lock_bits(lock_bits),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext), .rd_req(rd_req), .rd_info(rd_info),
    .rd_valid(rd_valid), .rd_data(rd_data), .nvm_valid(nvm_valid), .nvm_req(nvm_req), .nvm_ready(nvm_ready));

// [design/isp_port.sv]
// Serial in-system programming port: frame shifter, command decoder, request FIFO.
// Assumes an outside array controller that owns flash page buffer, flash and EEPROM,
// drains nvm requests and answers a read one cycle after rd_req.

// ----------------------------------------
// Request FIFO
// ----------------------------------------
module isp_req_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    import isp_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_idx;
        logic [AW-1:0] rd_idx;
        logic [AW:0] count;
    } fifo_s;
    fifo_s st_r, st_nxt;
    logic push, pop;

    assign in_ready = st_r.count != (AW+1)'(DEPTH);
    assign out_valid = st_r.count != '0;
    assign out_data = st_r.mem[st_r.rd_idx];

    always_comb begin
        st_nxt = st_r;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            st_nxt.mem[st_r.wr_idx] = in_data;
            st_nxt.wr_idx = st_r.wr_idx + 1'b1;
        end
        if (pop) begin
            st_nxt.rd_idx = st_r.rd_idx + 1'b1;
        end
        case ({push, pop})
            2'b10: st_nxt.count = st_r.count + 1'b1;
            2'b01: st_nxt.count = st_r.count - 1'b1;
            default: st_nxt.count = st_r.count;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ----------------------------------------
// Port top
// ----------------------------------------
module isp_port #(
    parameter int FLASH_WAIT = isp_pkg::FLASH_PAGE_WAIT_CYC,
    parameter int EEPROM_WAIT = isp_pkg::EEPROM_BYTE_WAIT_CYC,
    parameter int ERASE_WAIT = isp_pkg::ERASE_WAIT_CYC,
    parameter logic [7:0] SIG0 = 8'h00,
    parameter logic [7:0] SIG1 = 8'h00,
    parameter logic [7:0] SIG2 = 8'h00,
    parameter logic [7:0] CAL_BYTE = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Programming pins
    input wire logic prog_reset_n,
    input wire logic prog_sck,
    input wire logic prog_serial_in,
    output logic prog_serial_out,
    // Status
    output logic prog_mode,
    output logic operation_pending_flag,
    output logic [7:0] lock_bits,
    output logic [7:0] fuse_low,
    output logic [7:0] fuse_high,
    output logic [7:0] fuse_ext,
    // Array read
    output logic rd_req,
    output isp_pkg::rd_req_s rd_info,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    // Array write requests
    output logic nvm_valid,
    output isp_pkg::nvm_req_s nvm_req,
    input wire logic nvm_ready
);
    import isp_pkg::*;
    // SIG0..SIG2 and CAL_BYTE defaults are arbitrary neutral values.

    typedef struct packed {
        logic [1:0] sck_sync;
        logic [1:0] sdi_sync;
        logic [1:0] rst_sync;
        logic sck_d;
        link_st_e state;
        logic [4:0] bit_cnt;
        logic [30:0] rx;
        logic [7:0] tx;
        logic sdo;
        logic [7:0] ext_addr;
        logic [7:0] lock;
        logic [7:0] f_lo;
        logic [7:0] f_hi;
        logic [7:0] f_ext;
        logic [WAIT_W-1:0] wait_cnt;
        logic pending;
        logic rd_req;
        rd_req_s rd_info;
        logic push;
        nvm_req_s req;
    } port_s;

    port_s st_r, st_nxt;
    logic fifo_in_ready;
    logic fifo_out_valid;
    nvm_req_s fifo_out;

    // Reads the slot that the signature select bits name
    function automatic logic [7:0] sig_byte(input logic [1:0] sel);
        case (sel)
            2'd0: sig_byte = SIG0;
            2'd1: sig_byte = SIG1;
            2'd2: sig_byte = SIG2;
            default: sig_byte = ERASED_BYTE;
        endcase
    endfunction

    isp_req_fifo #(
        .W($bits(nvm_req_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(st_r.push),
        .in_data(st_r.req),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out),
        .out_ready(nvm_ready)
    );

    assign prog_serial_out = st_r.sdo;
    assign prog_mode = st_r.state == ST_ENABLED;
    assign operation_pending_flag = st_r.pending;
    assign lock_bits = st_r.lock;
    assign fuse_low = st_r.f_lo;
    assign fuse_high = st_r.f_hi;
    assign fuse_ext = st_r.f_ext;
    assign rd_req = st_r.rd_req;
    assign rd_info = st_r.rd_info;
    assign nvm_valid = fifo_out_valid;
    assign nvm_req = fifo_out;

    always_comb begin
        logic rise, fall, sdi, in_prog;
        logic [7:0] b1, b2, b3, b4;
        st_nxt = st_r;
        st_nxt.rd_req = 1'b0;
        st_nxt.push = 1'b0;
        // Two-stage synchronisers; only stage 1 is read downstream
        st_nxt.sck_sync = {st_r.sck_sync[0], prog_sck};
        st_nxt.sdi_sync = {st_r.sdi_sync[0], prog_serial_in};
        st_nxt.rst_sync = {st_r.rst_sync[0], prog_reset_n};
        st_nxt.sck_d = st_r.sck_sync[1];
        // Phases longer than two mclk cycles are seen reliably
        rise = st_r.sck_sync[1] && !st_r.sck_d;
        fall = !st_r.sck_sync[1] && st_r.sck_d;
        sdi = st_r.sdi_sync[1];
        in_prog = !st_r.rst_sync[1];
        // Bytes as they stand just before the last bit of the frame
        b1 = st_r.rx[30:23];
        b2 = st_r.rx[22:15];
        b3 = st_r.rx[14:7];
        b4 = {st_r.rx[6:0], sdi};
        if (st_r.wait_cnt != '0) begin
            st_nxt.wait_cnt = st_r.wait_cnt - 1'b1;
        end
        // Pending while timed write runs, requests queue or the queue is full
        st_nxt.pending = (st_r.wait_cnt != '0) || fifo_out_valid || !fifo_in_ready || st_r.push;
        if (rd_valid) begin
            st_nxt.tx = rd_data;
        end

        case (st_r.state)
            ST_IDLE: begin
                st_nxt.bit_cnt = '0;
                st_nxt.sdo = 1'b0;
                if (in_prog) begin
                    st_nxt.state = ST_SYNC;
                end
            end
            ST_SYNC, ST_ENABLED: begin
                if (!in_prog) begin
                    // Leaving programming mode drops enable and the frame
                    st_nxt.state = ST_IDLE;
                    st_nxt.ext_addr = '0;
                end else begin
                    if (fall) begin
                        st_nxt.sdo = st_r.tx[7];
                        st_nxt.tx = {st_r.tx[6:0], 1'b0};
                    end
                    if (rise) begin
                        st_nxt.rx = {st_r.rx[29:0], sdi};
                        st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
                        if (st_r.bit_cnt[2:0] == 3'd7) begin
                            // Echo each byte during the next one
                            st_nxt.tx = {st_r.rx[6:0], sdi};
                        end
                        if (st_r.bit_cnt == 5'd23 && st_r.state == ST_ENABLED) begin
                            b3 = {st_r.rx[6:0], sdi};
                            b2 = st_r.rx[14:7];
                            b1 = st_r.rx[22:15];
                            case (b1)
                                OP_POLL: st_nxt.tx = {7'h00, st_r.pending};
                                OP_RD_HI, OP_RD_LO: begin
                                    st_nxt.rd_req = 1'b1;
                                    st_nxt.rd_info = '{eeprom: 1'b0, hi: b1 == OP_RD_HI,
                                                       addr: {st_r.ext_addr, b2, b3}};
                                end
                                OP_RD_EE: begin
                                    st_nxt.rd_req = 1'b1;
                                    st_nxt.rd_info = '{eeprom: 1'b1, hi: 1'b0,
                                                       addr: {12'h000, b2[3:0], b3}};
                                end
                                OP_RD_LOCK_FHI: st_nxt.tx = (b2 == OP2_SEL_HI) ? st_r.f_hi : st_r.lock;
                                OP_RD_FUSE: st_nxt.tx = (b2 == OP2_SEL_HI) ? st_r.f_ext : st_r.f_lo;
                                OP_RD_SIG: st_nxt.tx = sig_byte(b3[1:0]);
                                OP_RD_CAL: st_nxt.tx = CAL_BYTE;
                                default: ;
                            endcase
                        end
                        if (st_r.bit_cnt == 5'd31) begin
                            // Whole frame in: execute it
                            if (b1 == OP_AC && b2 == OP2_ENABLE) begin
                                st_nxt.state = ST_ENABLED;
                            end else if (st_r.state == ST_ENABLED) begin
                                st_nxt.req.data = b4;
                                st_nxt.req.addr = {st_r.ext_addr, b2, b3};
                                case (b1)
                                    OP_AC: begin
                                        case (b2)
                                            OP2_ERASE: begin
                                                st_nxt.push = 1'b1;
                                                st_nxt.req.op = NVM_CHIP_ERASE;
                                                st_nxt.req.data = ERASED_BYTE;
                                                st_nxt.lock = ERASED_BYTE;
                                                st_nxt.wait_cnt = WAIT_W'(ERASE_WAIT);
                                            end
                                            // 0 programs a bit, 1 leaves it unprogrammed
                                            OP2_WR_LOCK: st_nxt.lock = b4;
                                            OP2_WR_FUSE_LO: st_nxt.f_lo = b4;
                                            OP2_WR_FUSE_HI: st_nxt.f_hi = b4;
                                            OP2_WR_FUSE_EXT: st_nxt.f_ext = b4;
                                            default: ;
                                        endcase
                                        if (b2 == OP2_WR_LOCK || b2 == OP2_WR_FUSE_LO ||
                                            b2 == OP2_WR_FUSE_HI || b2 == OP2_WR_FUSE_EXT) begin
                                            st_nxt.wait_cnt = WAIT_W'(FLASH_WAIT);
                                        end
                                    end
                                    OP_LOAD_EXT: st_nxt.ext_addr = b3;
                                    OP_LOAD_LO, OP_LOAD_HI: begin
                                        st_nxt.push = 1'b1;
                                        st_nxt.req.op = (b1 == OP_LOAD_HI) ? NVM_LOAD_HI : NVM_LOAD_LO;
                                        st_nxt.req.addr = {17'h00000, b3[6:0]};
                                    end
                                    OP_LOAD_EE: begin
                                        st_nxt.push = 1'b1;
                                        st_nxt.req.op = NVM_EE_LOAD;
                                        st_nxt.req.addr = {22'h000000, b3[1:0]};
                                    end
                                    OP_WR_PAGE: begin
                                        st_nxt.push = 1'b1;
                                        st_nxt.req.op = NVM_WRITE_PAGE;
                                        st_nxt.req.addr = {st_r.ext_addr, b2, 8'h00};
                                        st_nxt.wait_cnt = WAIT_W'(FLASH_WAIT);
                                    end
                                    OP_WR_EE: begin
                                        // Array controller erases then writes the byte
                                        st_nxt.push = 1'b1;
                                        st_nxt.req.op = NVM_EE_WRITE;
                                        st_nxt.req.addr = {12'h000, b2[3:0], b3};
                                        st_nxt.wait_cnt = WAIT_W'(EEPROM_WAIT);
                                    end
                                    OP_WR_EE_PAGE: begin
                                        st_nxt.push = 1'b1;
                                        st_nxt.req.op = NVM_EE_WRITE_PAGE;
                                        st_nxt.req.addr = {12'h000, b2[3:0], b3[7:2], 2'b00};
                                        st_nxt.wait_cnt = WAIT_W'(EEPROM_WAIT);
                                    end
                                    default: ;
                                endcase
                                // A full queue drops the request; pending shows it
                                if (!fifo_in_ready) begin
                                    st_nxt.push = 1'b0;
                                end
                            end
                        end
                    end
                end
            end
            default: st_nxt.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.sck_sync <= 2'b00;
            st_r.rst_sync <= 2'b11;
            st_r.state <= ST_IDLE;
            st_r.lock <= FUSE_RESET;
            st_r.f_lo <= FUSE_RESET;
            st_r.f_hi <= FUSE_RESET;
            st_r.f_ext <= FUSE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// [inc/isp_pkg.sv]
// Constants, opcodes and carrier types of the serial programming port.
// Assumes a 100 MHz mclk and an outside array controller for flash and EEPROM.
package isp_pkg;
    // ----------------------------------------
    // Clock and wait times
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int FLASH_PAGE_WAIT_NS = 4500000;
    localparam int EEPROM_BYTE_WAIT_NS = 3600000;
    localparam int ERASE_WAIT_NS = 9000000;
    localparam int FLASH_PAGE_WAIT_CYC = (FLASH_PAGE_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int EEPROM_BYTE_WAIT_CYC = (EEPROM_BYTE_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_WAIT_CYC = (ERASE_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_W = 20;
    localparam int FIFO_DEPTH = 32;
    // ----------------------------------------
    // Instruction bytes
    // ----------------------------------------
    localparam logic [7:0] OP_AC = 8'hac;
    localparam logic [7:0] OP2_ENABLE = 8'h53;
    localparam logic [7:0] OP2_ERASE = 8'h80;
    localparam logic [7:0] OP2_WR_LOCK = 8'he0;
    localparam logic [7:0] OP2_WR_FUSE_LO = 8'ha0;
    localparam logic [7:0] OP2_WR_FUSE_HI = 8'ha8;
    localparam logic [7:0] OP2_WR_FUSE_EXT = 8'ha4;
    localparam logic [7:0] OP_POLL = 8'hf0;
    localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_LOAD_EE = 8'hc1;
    localparam logic [7:0] OP_RD_HI = 8'h28;
    localparam logic [7:0] OP_RD_LO = 8'h20;
    localparam logic [7:0] OP_RD_EE = 8'ha0;
    localparam logic [7:0] OP_RD_LOCK_FHI = 8'h58;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP2_SEL_HI = 8'h08;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_WR_EE = 8'hc0;
    localparam logic [7:0] OP_WR_EE_PAGE = 8'hc2;
    // ----------------------------------------
    // Reset values (1 = unprogrammed)
    // ----------------------------------------
    localparam logic [7:0] FUSE_RESET = 8'hff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        NVM_LOAD_LO = 3'h0, NVM_LOAD_HI = 3'h1, NVM_WRITE_PAGE = 3'h2, NVM_EE_LOAD = 3'h3,
        NVM_EE_WRITE = 3'h4, NVM_EE_WRITE_PAGE = 3'h5, NVM_CHIP_ERASE = 3'h6
    } nvm_op_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_SYNC = 3'b010, ST_ENABLED = 3'b100
    } link_st_e;
    typedef struct packed {
        nvm_op_e op;
        logic [23:0] addr;
        logic [7:0] data;
    } nvm_req_s;
    typedef struct packed {
        logic eeprom;
        logic hi;
        logic [23:0] addr;
    } rd_req_s;
endpackage
